// File: logic/lcs_pkg.sv
package lcs_pkg;
   localparam int SMP_W = 24;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   // register offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h1;
   localparam logic [3:0] OFF_IRQ_ST = 4'h2;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
   localparam logic [3:0] OFF_WINDOW = 4'h4;
   localparam logic [3:0] OFF_TOL = 4'h5;
   localparam logic [3:0] OFF_GRAV = 4'h6;
   localparam logic [3:0] OFF_WEIGHT = 4'h7;
   localparam logic [3:0] OFF_FILT = 4'h8;
   // control bits
   localparam int CTRL_SYM_REF = 0;
   localparam int CTRL_HOLD = 1;
   localparam int CTRL_SETTLE_EN = 2;
   localparam logic [2:0] CTRL_RST = 3'h5;
   // status bits
   localparam int ST_SETTLED = 0;
   localparam int ST_FULLSCALE = 1;
   localparam int ST_SUP_OVER = 2;
   localparam int ST_SUP_UNDER = 3;
   localparam int ST_HOLD = 4;
   localparam int ST_SWITCH = 5;
   // irq bits: settled rise, fullscale, supply range
   localparam int IRQ_W = 3;
   // settle window time and counts
   localparam int WINDOW_MS_DEF = 100;
   localparam int CLK_MHZ = 100;
   localparam logic [31:0] WINDOW_CYC_DEF =
      32'(WINDOW_MS_DEF * 1000 * CLK_MHZ);
   localparam logic [SMP_W-1:0] TOL_DEF = 24'h000008;
   // gravity as q8.24: about 9.80682 default, standard constant
   localparam logic [31:0] GRAV_STD = 32'h09ce8ba2;
   localparam logic [SMP_W-1:0] FS_POS = 24'h7fffff;
   localparam logic [SMP_W-1:0] FS_NEG = 24'h800000;
   localparam logic [15:0] SUP_MIN_DEF = 16'h1000;
   localparam logic [15:0] SUP_MAX_DEF = 16'hf000;
   localparam int FILT_SHIFT = 3;

   typedef struct packed {
      logic valid;
      logic signed [SMP_W-1:0] bridge;
      logic [15:0] supply;
   } lcs_sample_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } lcs_bus_s;
endpackage

// File: logic/lcs_settle.sv
`timescale 1ns/1ps
module lcs_settle (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic enable,
   input wire logic sample_stb,
   input wire logic signed [23:0] value,
   input wire logic [23:0] tol,
   input wire logic [31:0] window,
   output logic settled
);
   logic signed [23:0] ref_q;
   logic [31:0] cnt_q;
   logic signed [24:0] diff;
   logic [24:0] mag;
   logic outside;

   assign diff = 25'(value) - 25'(ref_q);
   assign mag = diff[24] ? 25'(-diff) : diff;
   assign outside = mag > {1'b0, tol};

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ref_q <= '0;
      end else if (clk_en && sample_stb && (outside || !enable)) begin
         ref_q <= value;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         settled <= 1'b0;
      end else if (clk_en) begin
         if (!enable) begin
            cnt_q <= '0;
            settled <= 1'b0;
         end else if (sample_stb && outside) begin
            cnt_q <= '0;
            settled <= 1'b0;
         end else if (cnt_q > window) begin
            settled <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end

   chk_settle_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && enable && sample_stb && outside |=> !settled)
      else $error("settled flag not cleared on band exit");
   chk_settle_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(settled) |-> $past(cnt_q) > $past(window))
      else $error("settled flag set before window elapsed");
endmodule // lcs_settle

// File: logic/lcs_top.sv
`timescale 1ns/1ps
// Contract
// - reference coupling switch is closed after reset
// - switch opens when symmetric reference cleared, closes when set
// - bridge value at full scale raises error flag in status
// - supply above or below valid range is reported in status
// - hold bit stops new samples entering the filter until released
// - settled flag set after load stays in band beyond window time
// - settled flag cleared at once on band exit; window restarts
// - settle detection is enabled from reset
// - window time and tolerance are writable and used by detector
// - settling is judged on the filtered value
// - gravity correction is writable and used in weight
// - weight scaled by configured gravity over standard gravity
module lcs_top (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire lcs_pkg::lcs_sample_s smp,
   input wire lcs_pkg::lcs_bus_s bus,
   output logic [31:0] rdata,
   output logic ref_switch_closed,
   output logic load_settled_flag,
   output logic irq
);
   logic [2:0] ctrl_q;
   logic [31:0] window_q;
   logic [23:0] tol_q;
   logic [31:0] grav_q;
   logic [2:0] irq_st_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_ev;
   logic signed [23:0] filt_q;
   logic signed [23:0] weight_q;
   logic filt_stb_q;
   logic fullscale_q;
   logic sup_over_q;
   logic sup_under_q;
   logic settled;
   logic settled_d1_q;
   logic input_hold_request;
   logic fwd;
   logic signed [24:0] fdiff;
   logic signed [56:0] prod;

   function automatic logic is_wr(input lcs_pkg::lcs_bus_s b,
                                  input logic [3:0] off);
      return b.wr && (b.addr == off);
   endfunction

   assign input_hold_request = ctrl_q[lcs_pkg::CTRL_HOLD];
   assign fwd = smp.valid && !input_hold_request;
   assign fdiff = 25'(smp.bridge) - 25'(filt_q);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_q <= lcs_pkg::CTRL_RST;
         window_q <= lcs_pkg::WINDOW_CYC_DEF;
         tol_q <= lcs_pkg::TOL_DEF;
         grav_q <= lcs_pkg::GRAV_STD;
      end else if (clk_en) begin
         if (is_wr(bus, lcs_pkg::OFF_CTRL)) begin
            ctrl_q <= bus.wdata[2:0];
         end
         if (is_wr(bus, lcs_pkg::OFF_WINDOW)) begin
            window_q <= bus.wdata;
         end
         if (is_wr(bus, lcs_pkg::OFF_TOL)) begin
            tol_q <= bus.wdata[23:0];
         end
         if (is_wr(bus, lcs_pkg::OFF_GRAV)) begin
            grav_q <= bus.wdata;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ref_switch_closed <= 1'b1;
      end else if (clk_en) begin
         ref_switch_closed <= ctrl_q[lcs_pkg::CTRL_SYM_REF];
      end
   end

   // first-order filter fed only when not held
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         filt_q <= '0;
         filt_stb_q <= 1'b0;
      end else if (clk_en) begin
         filt_stb_q <= fwd;
         if (fwd) begin
            filt_q <= filt_q + 24'(fdiff >>> lcs_pkg::FILT_SHIFT);
         end
      end
   end

   assign prod = 57'(filt_q) * 57'($signed({1'b0, grav_q}));
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         weight_q <= '0;
      end else if (clk_en && filt_stb_q) begin
         weight_q <= 24'(prod / $signed(57'(lcs_pkg::GRAV_STD)));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         fullscale_q <= 1'b0;
         sup_over_q <= 1'b0;
         sup_under_q <= 1'b0;
      end else if (clk_en && smp.valid) begin
         fullscale_q <= (smp.bridge == lcs_pkg::FS_POS) ||
                        (smp.bridge == lcs_pkg::FS_NEG);
         sup_over_q <= smp.supply > lcs_pkg::SUP_MAX_DEF;
         sup_under_q <= smp.supply < lcs_pkg::SUP_MIN_DEF;
      end
   end

   lcs_settle u_settle (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .enable(ctrl_q[lcs_pkg::CTRL_SETTLE_EN]),
      .sample_stb(filt_stb_q),
      .value(filt_q),
      .tol(tol_q),
      .window(window_q),
      .settled(settled)
   );

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         load_settled_flag <= 1'b0;
         settled_d1_q <= 1'b0;
      end else if (clk_en) begin
         load_settled_flag <= settled;
         settled_d1_q <= settled;
      end
   end

   assign irq_ev = {sup_over_q | sup_under_q, fullscale_q,
                    settled & ~settled_d1_q};

   // sticky status, set wins over clear
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_st_q <= '0;
         irq_mask_q <= '0;
      end else if (clk_en) begin
         if (is_wr(bus, lcs_pkg::OFF_IRQ_MASK)) begin
            irq_mask_q <= bus.wdata[2:0];
         end
         if (is_wr(bus, lcs_pkg::OFF_IRQ_ST)) begin
            irq_st_q <= (irq_st_q & ~bus.wdata[2:0]) | irq_ev;
         end else begin
            irq_st_q <= irq_st_q | irq_ev;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |((irq_st_q | irq_ev) & irq_mask_q);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata <= '0;
      end else if (clk_en) begin
         rdata <= '0;
         if (bus.rd) begin
            unique case (bus.addr)
               lcs_pkg::OFF_CTRL: rdata <= {29'h0, ctrl_q};
               lcs_pkg::OFF_STATUS: rdata <= {26'h0, ref_switch_closed,
                  input_hold_request, sup_under_q, sup_over_q,
                  fullscale_q, load_settled_flag};
               lcs_pkg::OFF_IRQ_ST: rdata <= {29'h0, irq_st_q};
               lcs_pkg::OFF_IRQ_MASK: rdata <= {29'h0, irq_mask_q};
               lcs_pkg::OFF_WINDOW: rdata <= window_q;
               lcs_pkg::OFF_TOL: rdata <= {8'h0, tol_q};
               lcs_pkg::OFF_GRAV: rdata <= grav_q;
               lcs_pkg::OFF_WEIGHT: rdata <= 32'(weight_q);
               lcs_pkg::OFF_FILT: rdata <= 32'(filt_q);
               default: rdata <= '0;
            endcase
         end
      end
   end

   chk_hold_freeze: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && input_hold_request |=> $stable(filt_q))
      else $error("filter moved while held");
   chk_switch_follow: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      clk_en |=> ref_switch_closed == $past(ctrl_q[0]))
      else $error("switch does not follow setting");
   chk_reset_closed: assert property (@(posedge ref_clk)
      $past(sys_rst) |-> ref_switch_closed)
      else $error("switch not closed after reset");
   chk_fs_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && smp.valid && smp.bridge == lcs_pkg::FS_POS
      |=> fullscale_q)
      else $error("full scale not flagged");
   chk_sup_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && smp.valid && smp.supply > lcs_pkg::SUP_MAX_DEF
      |=> sup_over_q)
      else $error("supply overrange not flagged");
   chk_window_wr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_wr(bus, lcs_pkg::OFF_WINDOW)
      |=> window_q == $past(bus.wdata))
      else $error("window write lost");
   chk_grav_wr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_wr(bus, lcs_pkg::OFF_GRAV)
      |=> grav_q == $past(bus.wdata))
      else $error("gravity write lost");
   chk_settle_en: assert property (@(posedge ref_clk)
      $past(sys_rst) |-> ctrl_q[lcs_pkg::CTRL_SETTLE_EN])
      else $error("settle detection off after reset");
   chk_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !(|(irq_st_q & irq_mask_q)) && !(|irq_ev) |=> !irq)
      else $error("irq without masked status");
   cov_hold: cover property (@(posedge ref_clk) input_hold_request ##1
      !input_hold_request);
   cov_settled: cover property (@(posedge ref_clk) $rose(load_settled_flag));
   cov_unsettle: cover property (@(posedge ref_clk) $fell(load_settled_flag));
   cov_irq: cover property (@(posedge ref_clk) $rose(irq));
   cov_fullscale: cover property (@(posedge ref_clk) $rose(fullscale_q));

   chk_fs_neg: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && smp.valid && smp.bridge == lcs_pkg::FS_NEG
      |=> fullscale_q)
      else $error("negative full scale not flagged");
   chk_fs_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && smp.valid && smp.bridge != lcs_pkg::FS_POS &&
      smp.bridge != lcs_pkg::FS_NEG |=> !fullscale_q)
      else $error("full scale flag stuck");
   chk_sup_under: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && smp.valid && smp.supply < lcs_pkg::SUP_MIN_DEF
      |=> sup_under_q)
      else $error("supply underrange not flagged");
   chk_sup_inside: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && smp.valid && smp.supply >= lcs_pkg::SUP_MIN_DEF &&
      smp.supply <= lcs_pkg::SUP_MAX_DEF |=> !sup_over_q && !sup_under_q)
      else $error("supply flag in range");
   chk_hold_fwd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !input_hold_request && smp.valid |=> filt_stb_q)
      else $error("unheld sample not forwarded");
   chk_hold_stb: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && input_hold_request |=> !filt_stb_q)
      else $error("held sample forwarded");
   chk_tol_wr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_wr(bus, lcs_pkg::OFF_TOL)
      |=> tol_q == $past(bus.wdata[23:0]))
      else $error("tolerance write lost");
   chk_ctrl_wr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_wr(bus, lcs_pkg::OFF_CTRL)
      |=> ctrl_q == $past(bus.wdata[2:0]))
      else $error("control write lost");
   chk_mask_wr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_wr(bus, lcs_pkg::OFF_IRQ_MASK)
      |=> irq_mask_q == $past(bus.wdata[2:0]))
      else $error("mask write lost");
   chk_settled_lag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> load_settled_flag == $past(settled))
      else $error("settled flag does not follow detector");
   chk_settle_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !settled |=> !load_settled_flag)
      else $error("settled flag held after detector cleared");
   chk_reset_window: assert property (@(posedge ref_clk)
      $past(sys_rst) |-> window_q == lcs_pkg::WINDOW_CYC_DEF)
      else $error("window not default after reset");
   chk_reset_grav: assert property (@(posedge ref_clk)
      $past(sys_rst) |-> grav_q == lcs_pkg::GRAV_STD)
      else $error("gravity not standard after reset");
   chk_weight_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !filt_stb_q |=> $stable(weight_q))
      else $error("weight moved without filter update");
   chk_filt_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !smp.valid |=> $stable(filt_q))
      else $error("filter moved without sample");
   chk_irq_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !is_wr(bus, lcs_pkg::OFF_IRQ_ST)
      |=> (irq_st_q & $past(irq_st_q)) == $past(irq_st_q))
      else $error("status bit lost without clear");
   chk_irq_w1c: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && is_wr(bus, lcs_pkg::OFF_IRQ_ST)
      |=> irq_st_q == (($past(irq_st_q) & ~$past(bus.wdata[2:0])) |
      $past(irq_ev)))
      else $error("status clear wrong");
   chk_irq_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && |(irq_ev & irq_mask_q) |=> irq)
      else $error("unmasked event without irq");
   chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !bus.rd |=> rdata == 32'h0)
      else $error("read data outside read cycle");
   chk_rd_ctrl: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && bus.rd && bus.addr == lcs_pkg::OFF_CTRL
      |=> rdata == {29'h0, $past(ctrl_q)})
      else $error("control readback wrong");
   chk_rd_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && bus.rd && bus.addr == lcs_pkg::OFF_STATUS
      |=> rdata[4] == $past(input_hold_request))
      else $error("hold status wrong");
   chk_rd_switch: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && bus.rd && bus.addr == lcs_pkg::OFF_STATUS
      |=> rdata[5] == $past(ref_switch_closed))
      else $error("switch status wrong");
   chk_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !clk_en |=> $stable(ctrl_q) && $stable(filt_q) && $stable(irq_st_q))
      else $error("state moved while clock enable low");
endmodule // lcs_top

// File: dv/lcs_sensor_model.sv
`timescale 1ns/1ps
module lcs_sensor_model (
   input wire logic ref_clk,
   input wire logic fire,
   input wire logic signed [23:0] bridge,
   input wire logic [15:0] supply,
   output lcs_pkg::lcs_sample_s smp
);
   initial smp = '0;
   // one-cycle strobe per sample; idle lines toggle so stale data never matches
   always @(posedge ref_clk) begin
      smp.valid <= fire;
      if (fire) begin
         smp.bridge <= bridge;
         smp.supply <= supply;
      end else begin
         smp.bridge <= ~smp.bridge;
         smp.supply <= ~smp.supply;
      end
   end
endmodule // lcs_sensor_model

// File: dv/test_load_cell_freeze_and_settle.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
   miscompares++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module test_load_cell_freeze_and_settle;
   logic ref_clk = 0, sys_rst = 1, clk_en = 1, fire = 0;
   logic signed [23:0] br = '0;
   logic [15:0] su = 16'h8000;
   lcs_pkg::lcs_bus_s bus = '0;
   lcs_pkg::lcs_sample_s smp;
   logic [31:0] rdata, v;
   logic ref_switch_closed, load_settled_flag, irq;
   int miscompares = 0, total_checks = 0;
   longint wexp;
   logic signed [23:0] ef = '0, b;
   logic [23:0] tb_b [4] = '{24'h7fffff, 24'h800000, 24'h000100, 24'h000100};
   logic [15:0] tb_s [4] = '{16'h8000, 16'h8000, 16'h0fff, 16'hf001};
   int tb_k [4] = '{1, 1, 3, 2};
   always #5 ref_clk = ~ref_clk;
   lcs_sensor_model i_src (.ref_clk(ref_clk), .fire(fire), .bridge(br),
      .supply(su), .smp(smp));
   lcs_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .smp(smp), .bus(bus), .rdata(rdata),
      .ref_switch_closed(ref_switch_closed),
      .load_settled_flag(load_settled_flag), .irq(irq));
   function automatic logic signed [23:0] nf(input logic signed [23:0] f, s);
      logic signed [24:0] d;
      d = 25'(s) - 25'(f);
      return f + 24'(d >>> 3);
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic send(input logic [23:0] x, input logic [15:0] s);
      @(posedge ref_clk);
      fire <= 1'b1;
      br <= x;
      su <= s;
      @(posedge ref_clk);
      fire <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic summarize();
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #50000;
      miscompares++;
      summarize();
   end
   initial begin
      void'($urandom(39));
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1 `CHK("switch", 1'b1, ref_switch_closed)
      `CHK("rst irq", 1'b0, irq)
      `CHK("rst settled", 1'b0, load_settled_flag)
      `CHK("rst rdata", 32'h0, rdata)
      rd(lcs_pkg::OFF_CTRL, v); `CHK("ctrl", 32'h5, v)
      rd(lcs_pkg::OFF_GRAV, v); `CHK("grav", lcs_pkg::GRAV_STD, v)
      rd(lcs_pkg::OFF_WINDOW, v); `CHK("win", lcs_pkg::WINDOW_CYC_DEF, v)
      rd(4'h9, v); `CHK("unmapped", 32'h0, v)
      wr(lcs_pkg::OFF_CTRL, 32'h4);
      rd(lcs_pkg::OFF_STATUS, v); `CHK("sw open", 1'b0, v[5])
      `CHK("sw pin", 1'b0, ref_switch_closed)
      wr(lcs_pkg::OFF_CTRL, 32'h5);
      rd(lcs_pkg::OFF_STATUS, v); `CHK("sw close", 1'b1, ref_switch_closed)
      wr(lcs_pkg::OFF_WINDOW, 32'd20);
      wr(lcs_pkg::OFF_TOL, 32'h4);
      wr(lcs_pkg::OFF_IRQ_MASK, 32'h7);
      // bench alone decides the hold span: one sample here
      wr(lcs_pkg::OFF_CTRL, 32'h7);
      send(24'($urandom_range(24'h0fffff)), 16'h8000);
      rd(lcs_pkg::OFF_FILT, v); `CHK("held filt", ef, v[23:0])
      rd(lcs_pkg::OFF_STATUS, v); `CHK("hold bit", 1'b1, v[4])
      wr(lcs_pkg::OFF_CTRL, 32'h5);
      for (int i = 0; i < 4; i++) begin
         b = 24'($urandom_range(24'h0fffff));
         send(b, 16'h8000);
         ef = nf(ef, b);
         rd(lcs_pkg::OFF_FILT, v); `CHK("filt", ef, v[23:0])
      end
      rd(lcs_pkg::OFF_WEIGHT, v); `CHK("weight std", {8'h00, ef}, v)
      wr(lcs_pkg::OFF_GRAV, 32'h01000000);
      b = 24'($urandom_range(24'h0fffff));
      send(b, 16'h8000);
      ef = nf(ef, b);
      wexp = longint'(ef) * 64'sh1000000 / longint'(lcs_pkg::GRAV_STD);
      rd(lcs_pkg::OFF_WEIGHT, v); `CHK("weight", 32'(wexp), v)
      @(posedge ref_clk) clk_en <= 1'b0;
      wr(lcs_pkg::OFF_GRAV, 32'h0);
      @(posedge ref_clk) clk_en <= 1'b1;
      rd(lcs_pkg::OFF_GRAV, v); `CHK("frozen", 32'h01000000, v)
      for (int i = 0; i < 4; i++) begin
         send(tb_b[i], tb_s[i]);
         rd(lcs_pkg::OFF_STATUS, v); `CHK("flag", 1'b1, v[tb_k[i]])
      end
      send(24'h000100, 16'h1000);
      rd(lcs_pkg::OFF_STATUS, v); `CHK("in range", 3'h0, v[3:1])
      repeat (12) @(posedge ref_clk);
      #1 `CHK("early", 1'b0, load_settled_flag)
      repeat (30) @(posedge ref_clk);
      #1 `CHK("settled", 1'b1, load_settled_flag)
      send(24'h010000, 16'h8000);
      repeat (3) @(posedge ref_clk);
      #1 `CHK("band exit", 1'b0, load_settled_flag)
      repeat (12) @(posedge ref_clk);
      #1 `CHK("restart", 1'b0, load_settled_flag)
      repeat (30) @(posedge ref_clk);
      #1 `CHK("resettled", 1'b1, load_settled_flag)
      `CHK("irq on", 1'b1, irq)
      rd(lcs_pkg::OFF_IRQ_ST, v); `CHK("irq st", 32'h7, v)
      wr(lcs_pkg::OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq mask", 1'b0, irq)
      wr(lcs_pkg::OFF_IRQ_ST, 32'h7);
      rd(lcs_pkg::OFF_IRQ_ST, v); `CHK("irq clr", 32'h0, v)
      wr(lcs_pkg::OFF_IRQ_MASK, 32'h7);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq off", 1'b0, irq)
      summarize();
   end
endmodule // test_load_cell_freeze_and_settle
